// File: rtl/msrb_pkg.sv
`default_nettype none

package msrb_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing: one memory cycle is 16 slots, two slots per phase M1..M8
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned MBUS_CYCLE_NS = 250;
    localparam int unsigned SLOTS_PER_CYCLE = 16;
    localparam int unsigned TICK_CYCLES =
        MBUS_CYCLE_NS / (CLK_PERIOD_NS * SLOTS_PER_CYCLE);
    localparam logic [1:0] TICK_LAST = 2'(TICK_CYCLES - 1);

    // slot 2k is the first half of phase M(k+1), slot 2k+1 its middle
    localparam logic [3:0] T_MAL_FALL = 4'h1;
    localparam logic [3:0] T_RAS_FALL = 4'h3;
    localparam logic [3:0] T_Q2 = 4'h4;
    localparam logic [3:0] T_WR_BEN = 4'h6;
    localparam logic [3:0] T_DATA = 4'h8;
    localparam logic [3:0] T_SEL_FALL = 4'h9;
    localparam logic [3:0] T_WE_FALL = 4'h9;
    localparam logic [3:0] T_SAMPLE = 4'hB;
    localparam logic [3:0] T_M7 = 4'hC;
    localparam logic [3:0] T_M8 = 4'hE;
    localparam logic [3:0] T_LAST = 4'hF;

    ////////////////////////////////////////////////////////////////////////
    // bus owner codes and status byte layout
    typedef enum logic [3:0] {
        OWN_REFRESH  = 4'h0,
        OWN_TX_DMA   = 4'h2,
        OWN_RX_DMA   = 4'h3,
        OWN_TX_BUF   = 4'h4,
        OWN_RX_BUF   = 4'h5,
        OWN_HOST_DIO = 4'h6,
        OWN_HOST_DMA = 4'h7,
        OWN_PROC_BUS = 4'h8,
        OWN_PROC_INT = 4'h9,
        OWN_NONE     = 4'hF
    } msrb_owner_t;

    localparam int unsigned ST_CODE = 0;
    localparam int unsigned ST_HDMA = 5;
    localparam int unsigned ST_RXDMA = 6;
    localparam int unsigned ST_NEWFR = 7;

    localparam logic [19:0] PROM_LAST_ADDR = 20'h0000F;
    localparam logic [19:0] DEFAULT_ADDR = 20'h00000;
    localparam logic PARITY_ODD = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [31:0] REG_CTRL = 32'h0000_0000;
    localparam logic [31:0] REG_STAT = 32'h0000_0004;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [3:0] CTRL_RST = 4'hC;
    localparam int unsigned CTRL_W = 4;
    localparam int unsigned STAT_PERR = 3;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic alt_parity_en;
        logic parity_en;
        logic proc_halt;
        logic soft_reset;
    } msrb_ctrl_t;

    typedef struct packed {
        msrb_owner_t owner;
        logic [19:0] addr;
        logic write;
        logic [15:0] wdata;
        logic code_fetch;
        logic rx_first;
    } msrb_req_t;

    localparam msrb_req_t IDLE_REQ = '{
        owner: OWN_NONE, addr: DEFAULT_ADDR, write: 1'b0,
        wdata: 16'h0000, code_fetch: 1'b0, rx_first: 1'b0};

    typedef struct packed {
        logic int_rst;
        logic reset_out;
        logic nocpu;
        logic perr_evt;
        msrb_owner_t owner;
        logic [15:0] rdata;
    } msrb_stat_t;

    typedef struct packed {
        logic [7:0] addr_data_high_byte;
        logic [7:0] addr_data_low_byte;
        logic ext_addr_parity_high;
        logic ext_addr_parity_low;
    } msrb_pin_in_t;

    typedef struct packed {
        logic ext_addr_pin_a;
        logic ext_addr_parity_high;
        logic ext_addr_pin_c;
        logic ext_addr_parity_low;
        logic [7:0] addr_data_high_byte;
        logic [7:0] addr_data_low_byte;
        logic eprom_select_n;
        logic row_strobe_n;
        logic column_strobe_n;
        logic write_strobe_n;
        logic buffer_direction;
        logic address_latch_n;
        logic dram_output_enable_n;
        logic buffer_enable_n;
        logic addr_prom_select_n;
        logic bus_request_pin;
        logic bus_grant_pin;
    } msrb_pin_out_t;

    typedef struct packed {
        logic bus;
        logic ext;
        logic ctl;
        logic bus_request_pin;
        logic bus_grant_pin;
    } msrb_pin_oe_t;

    typedef struct packed {
        logic membus_clock_a;
        logic membus_clock_b;
        logic front_end_osc_out;
    } msrb_clk_t;

endpackage

`default_nettype wire

// File: rtl/msrb_phase_gen.sv
`default_nettype none

module msrb_phase_gen (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic tick_o,
    output logic [3:0] slot_o,
    output msrb_pkg::msrb_clk_t clk_o
);

    typedef struct packed {
        logic [1:0] div;
        logic [3:0] slot;
        msrb_pkg::msrb_clk_t clk;
    } msrb_phase_st_t;

    msrb_phase_st_t s;
    msrb_phase_st_t n;
    logic tick;
    logic [3:0] tn;

    ////////////////////////////////////////////////////////////////////////
    // free running: only the power-on reset stops it, never the
    // internal reset, so the clock pins keep toggling through it
    always_comb begin
        n = s;
        tick = (s.div == msrb_pkg::TICK_LAST);
        tn = s.slot + 4'h1;
        n.clk.front_end_osc_out = !s.clk.front_end_osc_out;
        if (tick) begin
            n.div = 2'h0;
            n.slot = tn;
            n.clk.membus_clock_a = !tn[0];
            n.clk.membus_clock_b = tn[1];
        end else begin
            n.div = s.div + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick_o = tick;
    assign slot_o = s.slot;
    assign clk_o = s.clk;

endmodule

`default_nettype wire

// File: rtl/msrb_ahb_regs.sv
`default_nettype none

module msrb_ahb_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire msrb_pkg::msrb_stat_t stat_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output msrb_pkg::msrb_ctrl_t ctrl_o
);

    typedef struct packed {
        logic wr_ctrl;
        logic wr_stat;
        msrb_pkg::msrb_ctrl_t ctrl;
        logic perr;
        logic [31:0] rdata;
    } msrb_regs_st_t;

    msrb_regs_st_t s;
    msrb_regs_st_t n;
    logic sel;
    logic wr_ok;

    // zero wait states: reads are decoded in the address phase
    always_comb begin
        n = s;
        sel = hsel_i && htrans_i[1] && hready_i;
        wr_ok = sel && hwrite_i && (hsize_i == msrb_pkg::HSIZE_WORD);
        n.wr_ctrl = wr_ok && (haddr_i == msrb_pkg::REG_CTRL);
        n.wr_stat = wr_ok && (haddr_i == msrb_pkg::REG_STAT);
        if (s.wr_ctrl) begin
            n.ctrl = msrb_pkg::msrb_ctrl_t'(hwdata_i[msrb_pkg::CTRL_W-1:0]);
        end
        if (s.wr_stat && hwdata_i[msrb_pkg::STAT_PERR]) begin
            n.perr = 1'b0;
        end
        // a new error in the clearing cycle is kept
        if (stat_i.perr_evt) begin
            n.perr = 1'b1;
        end
        n.rdata = 32'h0000_0000;
        if (sel && !hwrite_i) begin
            if (haddr_i == msrb_pkg::REG_CTRL) begin
                n.rdata = {28'h0000000, n.ctrl};
            end else if (haddr_i == msrb_pkg::REG_STAT) begin
                n.rdata = {stat_i.rdata, 8'h00, stat_i.owner, n.perr,
                           stat_i.nocpu, stat_i.reset_out, stat_i.int_rst};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.ctrl <= msrb_pkg::msrb_ctrl_t'(msrb_pkg::CTRL_RST);
        end else begin
            s <= n;
        end
    end

    assign hrdata_o = s.rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign ctrl_o = s.ctrl;

endmodule

`default_nettype wire

// File: rtl/msrb_top.sv
// Design decisions made here: the AHB-Lite register port and the address map.
`default_nettype none

module msrb_top (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic SYSTEM_RESET_IN_I,
    input wire logic NO_PROC_MODE_I,
    input wire logic REQ_VALID_I,
    input wire msrb_pkg::msrb_req_t REQ_I,
    output logic REQ_READY_O,
    input wire logic HOST_DMA_ACTIVE_I,
    output logic RESP_VALID_O,
    output logic [15:0] RESP_DATA_O,
    output logic RESP_PERR_O,
    input wire msrb_pkg::msrb_pin_in_t PIN_I,
    output msrb_pkg::msrb_pin_out_t PIN_O,
    output msrb_pkg::msrb_pin_oe_t PIN_OE_O,
    output msrb_pkg::msrb_clk_t CLK_O,
    output logic RESET_OUT_O,
    output logic REFRESH_INDICATOR_O
);

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic nocpu_s1;
        logic nocpu_s2;
        msrb_pkg::msrb_pin_in_t pin_s1;
        msrb_pkg::msrb_pin_in_t pin_s2;
        logic int_rst;
        logic first;
        msrb_pkg::msrb_req_t cur;
        logic dflt;
        logic hdma;
        msrb_pkg::msrb_pin_out_t pins;
        msrb_pkg::msrb_pin_oe_t oe;
        logic reset_out;
        logic refresh;
        logic resp_valid;
        logic [15:0] resp_data;
        logic resp_perr;
        logic perr_evt;
    } msrb_core_st_t;

    msrb_core_st_t s;
    msrb_core_st_t n;
    msrb_pkg::msrb_ctrl_t ctrl;
    msrb_pkg::msrb_stat_t stat;
    logic tick;
    logic [3:0] slot;
    logic [3:0] tn;
    logic boundary;
    logic ready;
    logic take;
    logic chk_en;
    logic perr;

    ////////////////////////////////////////////////////////////////////////
    // phase sequencer and register slave

    msrb_phase_gen u_phase (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .tick_o(tick),
        .slot_o(slot),
        .clk_o(CLK_O)
    );

    msrb_ahb_regs u_regs (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .hsel_i(HSEL_I),
        .haddr_i(HADDR_I),
        .htrans_i(HTRANS_I),
        .hwrite_i(HWRITE_I),
        .hsize_i(HSIZE_I),
        .hwdata_i(HWDATA_I),
        .hready_i(HREADY_I),
        .stat_i(stat),
        .hrdata_o(HRDATA_O),
        .hreadyout_o(HREADYOUT_O),
        .hresp_o(HRESP_O),
        .ctrl_o(ctrl)
    );

    assign stat = '{int_rst: s.int_rst, reset_out: s.reset_out,
                    nocpu: s.nocpu_s2, perr_evt: s.perr_evt,
                    owner: s.cur.owner, rdata: s.resp_data};

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic par(input logic [7:0] d);
        par = (^d) ^ msrb_pkg::PARITY_ODD;
    endfunction

    function automatic logic [7:0] status_byte(
        input msrb_pkg::msrb_req_t r,
        input logic hd
    );
        logic [7:0] b;
        b = 8'h00;
        b[msrb_pkg::ST_CODE] = (r.owner == msrb_pkg::OWN_PROC_BUS) &&
                               r.code_fetch;
        // device code bit 0 is the owner code's most significant bit
        b[4:1] = {r.owner[0], r.owner[1], r.owner[2], r.owner[3]};
        b[msrb_pkg::ST_HDMA] = hd;
        b[msrb_pkg::ST_RXDMA] = (r.owner == msrb_pkg::OWN_RX_DMA) &&
                                r.write;
        b[msrb_pkg::ST_NEWFR] = b[msrb_pkg::ST_RXDMA] && r.rx_first;
        return b;
    endfunction

    function automatic msrb_pkg::msrb_pin_out_t drive_pins(
        input logic [3:0] t,
        input msrb_pkg::msrb_req_t r,
        input logic hd
    );
        msrb_pkg::msrb_pin_out_t p;
        logic [4:0] ax;
        logic [14:0] a;
        logic prom;
        logic sel_win;
        p = '1;
        ax = r.addr[19:15];
        a = r.addr[14:0];
        prom = !r.write && (r.addr <= msrb_pkg::PROM_LAST_ADDR);
        sel_win = (t >= msrb_pkg::T_SEL_FALL) && (t < msrb_pkg::T_M7);
        if (t < msrb_pkg::T_Q2) begin
            p.ext_addr_pin_a = ax[0];
            p.ext_addr_parity_high = ax[1];
            p.ext_addr_pin_c = ax[2];
            p.ext_addr_parity_low = ax[3];
            p.addr_data_high_byte = {a[6:0], ax[4]};
            p.addr_data_low_byte = a[14:7];
            p.eprom_select_n = 1'b1;
        end else begin
            // no latch needed: held from here to the end of the cycle
            p.ext_addr_pin_a = a[12];
            p.ext_addr_pin_c = a[14];
            p.eprom_select_n = a[13];
            if (t < msrb_pkg::T_DATA) begin
                p.ext_addr_parity_high = ax[0];
                p.ext_addr_parity_low = ax[2];
                p.addr_data_high_byte = status_byte(r, hd);
                p.addr_data_low_byte = {a[6:0], ax[4]};
            end else begin
                p.addr_data_high_byte = r.wdata[15:8];
                p.addr_data_low_byte = r.wdata[7:0];
                p.ext_addr_parity_high = par(r.wdata[15:8]);
                p.ext_addr_parity_low = par(r.wdata[7:0]);
            end
        end
        p.address_latch_n = (t < msrb_pkg::T_MAL_FALL);
        // row strobe always pulsed: harmless extra refresh of the row
        p.row_strobe_n = !((t >= msrb_pkg::T_RAS_FALL) &&
                           (t < msrb_pkg::T_M7));
        p.column_strobe_n = 1'b1;
        p.dram_output_enable_n = 1'b1;
        p.buffer_direction = r.write;
        if (r.write) begin
            p.buffer_enable_n = !((t >= msrb_pkg::T_WR_BEN) &&
                                  (t < msrb_pkg::T_LAST));
            p.write_strobe_n = !((t >= msrb_pkg::T_WE_FALL) &&
                                 (t < msrb_pkg::T_M8));
        end else begin
            p.write_strobe_n = 1'b1;
            p.buffer_enable_n = !sel_win;
            p.addr_prom_select_n = !(prom && sel_win);
        end
        return p;
    endfunction

    function automatic msrb_pkg::msrb_pin_oe_t drive_oe(
        input logic [3:0] t,
        input logic wr,
        input logic nocpu
    );
        msrb_pkg::msrb_pin_oe_t o;
        o.bus = (t < msrb_pkg::T_DATA) || wr;
        o.ext = 1'b1;
        o.ctl = 1'b1;
        o.bus_request_pin = nocpu;
        o.bus_grant_pin = !nocpu;
        return o;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // cycle engine

    assign tn = slot + 4'h1;
    assign boundary = tick && (slot == msrb_pkg::T_LAST);
    // the first cycle after reset is always the idle default read
    assign ready = boundary && !s.int_rst && !s.first;
    assign take = ready && REQ_VALID_I &&
                  (REQ_I.owner != msrb_pkg::OWN_PROC_INT);
    assign chk_en = ctrl.parity_en && ctrl.alt_parity_en && !s.dflt;
    assign perr = (^{s.pin_s2.addr_data_high_byte,
                     s.pin_s2.ext_addr_parity_high} != msrb_pkg::PARITY_ODD) ||
                  (^{s.pin_s2.addr_data_low_byte,
                     s.pin_s2.ext_addr_parity_low} != msrb_pkg::PARITY_ODD);

    always_comb begin
        n = s;
        n.resp_valid = 1'b0;
        n.perr_evt = 1'b0;
        n.rst_s1 = SYSTEM_RESET_IN_I;
        n.rst_s2 = s.rst_s1;
        n.nocpu_s1 = NO_PROC_MODE_I;
        n.nocpu_s2 = s.nocpu_s1;
        n.pin_s1 = PIN_I;
        n.pin_s2 = s.pin_s1;
        n.int_rst = s.rst_s2 || ctrl.soft_reset;
        if (s.int_rst) begin
            n.first = 1'b1;
            n.dflt = 1'b1;
            n.cur = msrb_pkg::IDLE_REQ;
            n.pins = '1;
            n.oe = '0;
            n.oe.bus_grant_pin = !s.nocpu_s2;
            n.oe.bus_request_pin = s.nocpu_s2;
            n.reset_out = 1'b0;
            n.refresh = 1'b0;
        end else begin
            if (boundary) begin
                n.first = 1'b0;
                n.hdma = HOST_DMA_ACTIVE_I;
                if (take) begin
                    n.cur = REQ_I;
                    n.dflt = 1'b0;
                end else begin
                    n.cur = msrb_pkg::IDLE_REQ;
                    n.dflt = 1'b1;
                    if (!s.first && !ctrl.proc_halt) begin
                        n.cur.owner = msrb_pkg::OWN_PROC_INT;
                    end
                end
            end
            // only non-refresh cycles exist here, so the indicator is
            // low from each M8 onward
            if (tick && (tn == msrb_pkg::T_M8)) begin
                n.reset_out = 1'b1;
                n.refresh = 1'b0;
            end
            if (tick) begin
                n.pins = drive_pins(tn, n.cur, n.hdma);
                n.oe = drive_oe(tn, n.cur.write, s.nocpu_s2);
            end
            if (tick && (slot == msrb_pkg::T_SAMPLE) && !s.cur.write) begin
                n.resp_data = {s.pin_s2.addr_data_high_byte,
                               s.pin_s2.addr_data_low_byte};
                if (!s.dflt) begin
                    n.resp_valid = 1'b1;
                    n.resp_perr = chk_en && perr;
                    n.perr_evt = chk_en && perr;
                end
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            s <= '0;
            s.rst_s1 <= 1'b1;
            s.rst_s2 <= 1'b1;
            s.int_rst <= 1'b1;
            s.first <= 1'b1;
            s.dflt <= 1'b1;
            s.cur <= msrb_pkg::IDLE_REQ;
            s.pins <= '1;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign REQ_READY_O = ready;
    assign RESP_VALID_O = s.resp_valid;
    assign RESP_DATA_O = s.resp_data;
    assign RESP_PERR_O = s.resp_perr;
    assign PIN_O = s.pins;
    assign PIN_OE_O = s.oe;
    assign RESET_OUT_O = s.reset_out;
    assign REFRESH_INDICATOR_O = s.refresh;

endmodule

`default_nettype wire

// File: tb/msrb_top_props.sv
`default_nettype none

module msrb_top_props (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic NO_PROC_MODE_I,
    input wire logic RESP_VALID_O,
    input wire msrb_pkg::msrb_pin_out_t PIN_O,
    input wire msrb_pkg::msrb_pin_oe_t PIN_OE_O,
    input wire msrb_pkg::msrb_clk_t CLK_O,
    input wire logic RESET_OUT_O,
    input wire logic REFRESH_INDICATOR_O
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);
    logic sel;
    assign sel = !PIN_O.addr_prom_select_n;
    ////////////////////////////////
    sequence prom_open;
        $fell(PIN_O.addr_prom_select_n);
    endsequence
    sequence prom_hold;
        sel [*8] ##1 !sel;
    endsequence
    // two edges back so the first toggle after release has landed
    chk_osc_runs: assert property (
        !$past(RST_I, 2) |->
        CLK_O.front_end_osc_out != $past(CLK_O.front_end_osc_out))
        else $error("oscillator output stopped");
    // first toggle after power-on comes late: clocks reset low at slot 0
    chk_clk_in_reset: assert property (
        !RESET_OUT_O |-> ##[1:6] $changed(CLK_O.membus_clock_a))
        else $error("memory-bus clock stopped in reset");
    chk_rst_float: assert property (
        $fell(RESET_OUT_O) |=> !PIN_OE_O.bus && !PIN_OE_O.ext && !PIN_OE_O.ctl)
        else $error("bus pins still driven in reset");
    chk_rst_grant: assert property (
        $fell(RESET_OUT_O) |-> ##[1:2]
        ((PIN_OE_O.bus_grant_pin != NO_PROC_MODE_I) &&
        (PIN_OE_O.bus_request_pin == NO_PROC_MODE_I)))
        else $error("grant or request drive wrong in reset");
    chk_rst_refr: assert property (
        !RESET_OUT_O |-> !REFRESH_INDICATOR_O)
        else $error("refresh indicator high");
    chk_rstout_m8: assert property (
        $rose(RESET_OUT_O) |->
        ##[0:2] (CLK_O.membus_clock_a && CLK_O.membus_clock_b))
        else $error("reset out rose outside phase eight");
    chk_prom_window: assert property (
        prom_open |=> prom_hold)
        else $error("prom select low for wrong length");
    chk_prom_ctl: assert property (
        sel && PIN_OE_O.ctl |-> !PIN_O.buffer_enable_n &&
        PIN_O.write_strobe_n && !PIN_O.buffer_direction && !PIN_OE_O.bus)
        else $error("prom read controls wrong");
    chk_prom_nocas: assert property (
        sel && PIN_OE_O.ctl |-> PIN_O.column_strobe_n &&
        PIN_O.dram_output_enable_n && !PIN_O.row_strobe_n)
        else $error("dram strobes wrong in prom read");
    chk_resp_sample: assert property (
        RESP_VALID_O |-> !$past(PIN_OE_O.bus, 3) ##1 !RESP_VALID_O)
        else $error("response not from released bus");
endmodule

bind msrb_top msrb_top_props i_msrb_top_props (.MCLK_I, .RST_I,
    .NO_PROC_MODE_I, .RESP_VALID_O, .PIN_O, .PIN_OE_O, .CLK_O,
    .RESET_OUT_O, .REFRESH_INDICATOR_O);

`default_nettype wire

// File: tb/msrb_prom_model.sv
`default_nettype none

module msrb_prom_model #(
    parameter logic [7:0] PROM_BYTE = 8'hA5
) (
    input wire msrb_pkg::msrb_pin_out_t pins_i,
    input wire msrb_pkg::msrb_pin_oe_t oe_i,
    output logic [17:0] pins_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic prom_on;
    // the prom sits on the high byte only; all else floats to pullups
    assign prom_on = oe_i.ctl && !pins_i.addr_prom_select_n;
    assign pins_o = {oe_i.bus ? pins_i.addr_data_high_byte :
        (prom_on ? PROM_BYTE : 8'hFF),
        oe_i.bus ? pins_i.addr_data_low_byte : 8'hFF,
        !oe_i.bus || pins_i.ext_addr_parity_high,
        !oe_i.bus || pins_i.ext_addr_parity_low};
endmodule

`default_nettype wire

// File: tb/test_membus_status_reset_bia_read.sv
`default_nettype none

module test_membus_status_reset_bia_read;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] PROM_BYTE = 8'hA5;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hresp;
    logic sys_rst = 1'b0, noproc = 1'b0, rq_v = 1'b0, rq_rdy, hdma = 1'b0;
    logic resp_v, perr, rst_out, refr;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
    logic [15:0] resp_d;
    logic [17:0] pin_i;
    msrb_pkg::msrb_req_t req = msrb_pkg::IDLE_REQ;
    msrb_pkg::msrb_pin_out_t pin_o;
    msrb_pkg::msrb_pin_oe_t pin_oe;
    msrb_pkg::msrb_clk_t clks;
    int miscompares = 0, n_compared = 0, cyc = 0;

    msrb_top i_msrb_top (.MCLK_I(clk), .RST_I(rst), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(msrb_pkg::HSIZE_WORD), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .SYSTEM_RESET_IN_I(sys_rst), .NO_PROC_MODE_I(noproc),
        .REQ_VALID_I(rq_v), .REQ_I(req), .REQ_READY_O(rq_rdy),
        .HOST_DMA_ACTIVE_I(hdma), .RESP_VALID_O(resp_v),
        .RESP_DATA_O(resp_d), .RESP_PERR_O(perr), .PIN_I(pin_i),
        .PIN_O(pin_o), .PIN_OE_O(pin_oe), .CLK_O(clks),
        .RESET_OUT_O(rst_out), .REFRESH_INDICATOR_O(refr));
    msrb_prom_model #(.PROM_BYTE(PROM_BYTE)) i_msrb_prom_model (
        .pins_i(pin_o), .oe_i(pin_oe), .pins_o(pin_i));

    always #2.5 clk = ~clk;
    // whole run is about a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end
    ////////////////////////////////
    task automatic summarize();
        if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rdv = hrdata;
    endtask
    task automatic wait_rst_out();
        int n;
        n = 0;
        while (rst_out !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
    endtask
    // f holds write, code fetch, first of frame, host dma busy
    task automatic mreq(input msrb_pkg::msrb_owner_t o, input logic [19:0] a,
        input logic [3:0] f);
        logic rx;
        logic [7:0] st;
        int n;
        rx = f[3] && (o == msrb_pkg::OWN_RX_DMA);
        st = {rx && f[1], rx, f[0], o[0], o[1], o[2], o[3],
            f[2] && (o == msrb_pkg::OWN_PROC_BUS)};
        @(posedge clk);
        req <= '{owner: o, addr: a, write: f[3], wdata: 16'h5A3C,
            code_fetch: f[2], rx_first: f[1]};
        rq_v <= 1'b1;
        hdma <= f[0];
        n = 0;
        @(posedge clk);
        while (rq_rdy !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        rq_v <= 1'b0;
        chk("taken", 1'b1, rq_rdy);
        repeat (14) @(posedge clk);
        #1;
        chk("status", st, pin_o.addr_data_high_byte);
        chk("ext", a[14:12], {pin_o.ext_addr_pin_c, pin_o.eprom_select_n,
            pin_o.ext_addr_pin_a});
        if (!f[3] && o != msrb_pkg::OWN_PROC_INT) begin
            n = 0;
            while (resp_v !== 1'b1 && n < 60) begin
                @(posedge clk);
                n++;
            end
            chk("respv", 1'b1, resp_v);
            chk("rdata", a <= 20'hF ? {PROM_BYTE, 8'hFF} : 16'hFFFF,
                resp_d);
            chk("perr", 1'b0, perr);
        end
    endtask
    task automatic rstchk(input logic np);
        @(posedge clk);
        noproc <= np;
        sys_rst <= np;
        if (!np) ahb(1'b1, msrb_pkg::REG_CTRL, 32'h0000000D);
        repeat (8) @(posedge clk);
        #1;
        chk("oe", {3'h0, np, ~np}, pin_oe);
        rdv = np ? pin_o.bus_request_pin : pin_o.bus_grant_pin;
        chk("drive", 1'b1, rdv);
        chk("rstout", 2'h0, {rst_out, refr});
        ahb(1'b0, msrb_pkg::REG_STAT, 32'h0);
        chk("stat", {np, 2'h1}, rdv & 32'h7);
        sys_rst <= 1'b0;
        ahb(1'b1, msrb_pkg::REG_CTRL, 32'h0000000C);
        wait_rst_out();
        chk("rstout", 1'b1, rst_out);
    endtask
    ////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        ahb(1'b0, msrb_pkg::REG_CTRL, 32'h0);
        chk("ctrl", 32'h0000000C, rdv);
        chk("hresp", 1'b0, hresp);
        ahb(1'b0, 32'h00000040, 32'h0);
        chk("unmapped", 32'h0, rdv);
        wait_rst_out();
        ahb(1'b0, msrb_pkg::REG_STAT, 32'h0);
        chk("owner", 4'hF, rdv[7:4]);
        // the first full cycle after reset is still ownerless
        repeat (60) @(posedge clk);
        ahb(1'b0, msrb_pkg::REG_STAT, 32'h0);
        chk("owner", 4'h9, rdv[7:4]);
        ahb(1'b1, msrb_pkg::REG_CTRL, 32'h0000000E);
        repeat (96) @(posedge clk);
        ahb(1'b0, msrb_pkg::REG_STAT, 32'h0);
        chk("owner", 4'hF, rdv[7:4]);
        ahb(1'b1, msrb_pkg::REG_CTRL, 32'h0000000C);
        mreq(msrb_pkg::OWN_RX_BUF, 20'h00003, 4'h0);
        mreq(msrb_pkg::OWN_PROC_BUS, 20'h0000F, 4'h4);
        mreq(msrb_pkg::OWN_PROC_BUS, 20'h05000, 4'h1);
        mreq(msrb_pkg::OWN_RX_DMA, 20'h06000, 4'hA);
        mreq(msrb_pkg::OWN_RX_DMA, 20'h06000, 4'h8);
        mreq(msrb_pkg::OWN_RX_DMA, 20'h00002, 4'h2);
        mreq(msrb_pkg::OWN_TX_DMA, 20'h07000, 4'hA);
        mreq(msrb_pkg::OWN_TX_BUF, 20'h01000, 4'h8);
        mreq(msrb_pkg::OWN_HOST_DIO, 20'h00007, 4'h4);
        mreq(msrb_pkg::OWN_HOST_DMA, 20'h02000, 4'h9);
        mreq(msrb_pkg::OWN_PROC_INT, 20'h00000, 4'h4);
        rstchk(1'b0);
        rstchk(1'b1);
        summarize();
    end
endmodule

`default_nettype wire
